/* rtl/sspg_defines.vh */
// Constants of the serial port GPIO and clock-stop block
// Summary of operation
// - Rx clock, rx frame, rx data, tx clock, tx frame may be GPIO inputs.
// - Rx clock, rx frame, tx clock, tx frame, tx data may be GPIO outputs.
// - GPIO inputs are sampled on the rising edge of the CPU clock.
// - GPIO outputs change after a rising CPU clock edge.
// - Master inverts internal tx frame into an active-low slave enable.
// - Slave inverts the active-low enable received on the frame pins.
// - Master lowers enable before a rising clock, then transfers on rising.
// - Bit clock period is one plus divide value CPU cycles, split into low and high times.
// - Low time is half period if divide odd or zero, else divide/2.
// - Mode 10b launches transmit bits on the rising bit clock edge.
// - Mode 10b samples receive data on the falling bit clock edge.
// - Mode 11b launches transmit bits on the falling bit clock edge.
// - Mode 11b samples receive data on the rising bit clock edge.
// - Enable lead is one low time in 10b, one period in 11b.
// - Enable hold is one period in 10b, one low time in 11b.
// - Master floats tx data after the final falling clock edge.
// - Slave floats tx data once the enable input returns high.
// - Slave drives its first bit from the second rising CPU clock edge after the enable falls.
// - High time is half period if divide odd or zero, else divide/2+1.
`ifndef SSPG_DEFINES_VH
`define SSPG_DEFINES_VH
`define SSPG_MODE_10 2'h2
`define SSPG_MODE_11 2'h3
`define SSPG_PIN_RXCLK 0
`define SSPG_PIN_RXFRM 1
`define SSPG_PIN_RXDAT 2
`define SSPG_PIN_TXCLK 3
`define SSPG_PIN_TXFRM 4
`define SSPG_PIN_TXDAT 5
`define SSPG_GPIO_IN_OK 6'h1F
`define SSPG_GPIO_OUT_OK 6'h3B
`define SSPG_FIFO_DEPTH 4
`endif

/* rtl/sspg_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
`default_nettype none
module sspg_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire sys_clk,
  input wire srst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire doWr;
  wire doRd;
  assign inReady = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_r];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  always @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end
  always @(posedge sys_clk) begin
    if (srst) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rdPtr_r + 1'b1;
      end
      if (doWr && !doRd) begin
        count_r <= count_r + 1'b1;
      end else if (doRd && !doWr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/sspg_port.v */
// Serial port top: GPIO use and clock-stop master or slave transfers
`include "sspg_defines.vh"
`default_nettype none
module sspg_port #(
  parameter WIDTH = 16,
  parameter DIVW = 8
) (
  input wire sys_clk,
  input wire srst,
  input wire [5:0] gpioEnable,
  input wire [5:0] gpioOutSel,
  input wire [5:0] gpioOutLevel,
  output reg [5:0] gpioInLevel,
  input wire spiEnable,
  input wire spiMaster,
  input wire [1:0] clockStopMode,
  input wire txClockPolarity,
  input wire txFramePolarity,
  input wire rxFramePolarity,
  input wire [DIVW-1:0] clockDivideValue,
  input wire txValid,
  output wire txReady,
  input wire [WIDTH-1:0] txWord,
  output reg rxValid,
  output reg [WIDTH-1:0] rxWord,
  output wire busy,
  input wire rxBitClockPinIn,
  output wire rxBitClockPinOut,
  output wire rxBitClockPinOe,
  input wire rxFramePinIn,
  output wire rxFramePinOut,
  output wire rxFramePinOe,
  input wire rxDataPinIn,
  input wire txBitClockPinIn,
  output wire txBitClockPinOut,
  output wire txBitClockPinOe,
  input wire txFramePinIn,
  output wire txFramePinOut,
  output wire txFramePinOe,
  input wire txDataPinIn,
  output wire txDataPinOut,
  output wire txDataPinOe
);
  // ------------------------------------------------------------
  // State codes
  // ------------------------------------------------------------
  localparam ST_IDLE = 4'h1;
  localparam ST_LEAD = 4'h2;
  localparam ST_BITS = 4'h4;
  localparam ST_HOLD = 4'h8;
  localparam CW = 5;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  wire [5:0] pinIn;
  reg [5:0] gpioOut_r;
  wire [5:0] inOk;
  wire [5:0] outOk;
  wire fifoValid;
  wire fifoReady;
  wire [WIDTH-1:0] fifoData;
  reg [3:0] state_r;
  reg [DIVW:0] divCnt_r;
  reg sclk_r;
  reg frame_r;
  reg [WIDTH-1:0] shTx_r;
  reg [WIDTH-1:0] shRx_r;
  reg [CW-1:0] bitCnt_r;
  reg txDrv_r;
  reg txBit_r;
  reg slvClkD_r;
  reg slvSelD_r;
  reg slvActive_r;
  wire mode11;
  wire divOdd;
  wire [DIVW:0] lowLen;
  wire [DIVW:0] highLen;
  wire [DIVW:0] periodLen;
  wire phaseEnd;
  wire slvSel;
  wire slvClk;
  wire slvRise;
  wire slvFall;
  wire slvLaunch;
  wire slvSample;
  wire isMaster;
  wire isSlave;

  // ------------------------------------------------------------
  // General-purpose I/O
  // ------------------------------------------------------------
  assign pinIn = {txDataPinIn, txFramePinIn, txBitClockPinIn,
    rxDataPinIn, rxFramePinIn, rxBitClockPinIn};
  assign inOk = gpioEnable & ~gpioOutSel & `SSPG_GPIO_IN_OK;
  assign outOk = gpioEnable & gpioOutSel & `SSPG_GPIO_OUT_OK;

  always @(posedge sys_clk) begin
    if (srst) begin
      gpioInLevel <= 6'h00;
      gpioOut_r <= 6'h00;
    end else begin
      gpioInLevel <= pinIn & inOk;
      gpioOut_r <= gpioOutLevel & outOk;
    end
  end

  // ------------------------------------------------------------
  // Transmit word FIFO
  // ------------------------------------------------------------
  sspg_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(`SSPG_FIFO_DEPTH),
    .AW(2)
  ) txFifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txWord),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  // ------------------------------------------------------------
  // Bit clock timing
  // ------------------------------------------------------------
  assign isMaster = spiEnable && spiMaster;
  assign isSlave = spiEnable && !spiMaster;
  assign mode11 = (clockStopMode == `SSPG_MODE_11);
  assign divOdd = clockDivideValue[0];
  // Period and half-period counts in cycles of the CPU clock
  assign periodLen = {1'b0, clockDivideValue} + 1'b1;
  assign lowLen = (divOdd || clockDivideValue == {DIVW{1'b0}}) ?
    (periodLen >> 1) : {1'b0, clockDivideValue >> 1};
  assign highLen = (divOdd || clockDivideValue == {DIVW{1'b0}}) ?
    (periodLen - (periodLen >> 1)) :
    ({1'b0, clockDivideValue >> 1} + 1'b1);
  assign phaseEnd = (divCnt_r <= 1);
  assign fifoReady = isMaster && (state_r == ST_IDLE);

  // ------------------------------------------------------------
  // Master sequencer and slave shift registers
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      divCnt_r <= {(DIVW+1){1'b0}};
      sclk_r <= 1'b0;
      frame_r <= 1'b0;
      shTx_r <= {WIDTH{1'b0}};
      shRx_r <= {WIDTH{1'b0}};
      bitCnt_r <= {CW{1'b0}};
      txDrv_r <= 1'b0;
      txBit_r <= 1'b0;
      rxValid <= 1'b0;
      rxWord <= {WIDTH{1'b0}};
    end else begin
      rxValid <= 1'b0;
      if (isSlave) begin
        sclk_r <= 1'b0;
        frame_r <= 1'b0;
        state_r <= ST_IDLE;
        txDrv_r <= slvActive_r;
        if (slvSel && !slvSelD_r) begin
          shTx_r <= {fifoData[WIDTH-2:0], 1'b0};
          txBit_r <= fifoData[WIDTH-1];
          bitCnt_r <= {CW{1'b0}};
        end else if (slvLaunch && bitCnt_r != {CW{1'b0}}) begin
          txBit_r <= shTx_r[WIDTH-1];
          shTx_r <= {shTx_r[WIDTH-2:0], 1'b0};
        end
        if (slvSample) begin
          shRx_r <= {shRx_r[WIDTH-2:0], rxDataPinIn};
          bitCnt_r <= bitCnt_r + 1'b1;
          if (bitCnt_r == WIDTH[CW-1:0] - 1'b1) begin
            rxValid <= 1'b1;
            rxWord <= {shRx_r[WIDTH-2:0], rxDataPinIn};
          end
        end
      end else begin
        case (state_r)
          ST_IDLE: begin
            sclk_r <= 1'b0;
            txDrv_r <= 1'b0;
            if (isMaster && fifoValid) begin
              state_r <= ST_LEAD;
              frame_r <= 1'b1;
              shTx_r <= fifoData;
              bitCnt_r <= {CW{1'b0}};
              divCnt_r <= mode11 ? periodLen : lowLen;
              txDrv_r <= mode11;
              txBit_r <= fifoData[WIDTH-1];
            end
          end
          ST_LEAD: begin
            if (phaseEnd) begin
              state_r <= ST_BITS;
              sclk_r <= 1'b1;
              divCnt_r <= highLen;
              txDrv_r <= 1'b1;
              if (!mode11) begin
                txBit_r <= shTx_r[WIDTH-1];
              end else begin
                shRx_r <= {shRx_r[WIDTH-2:0], rxDataPinIn};
              end
              shTx_r <= {shTx_r[WIDTH-2:0], 1'b0};
            end else begin
              divCnt_r <= divCnt_r - 1'b1;
            end
          end
          ST_BITS: begin
            if (!phaseEnd) begin
              divCnt_r <= divCnt_r - 1'b1;
            end else if (sclk_r) begin
              sclk_r <= 1'b0;
              divCnt_r <= lowLen;
              bitCnt_r <= bitCnt_r + 1'b1;
              if (!mode11) begin
                shRx_r <= {shRx_r[WIDTH-2:0], rxDataPinIn};
              end else if (bitCnt_r != WIDTH[CW-1:0] - 1'b1) begin
                txBit_r <= shTx_r[WIDTH-1];
                shTx_r <= {shTx_r[WIDTH-2:0], 1'b0};
              end
              if (bitCnt_r == WIDTH[CW-1:0] - 1'b1) begin
                state_r <= ST_HOLD;
                divCnt_r <= mode11 ? lowLen : periodLen;
                rxValid <= 1'b1;
                rxWord <= mode11 ? shRx_r :
                  {shRx_r[WIDTH-2:0], rxDataPinIn};
              end
            end else begin
              sclk_r <= 1'b1;
              divCnt_r <= highLen;
              if (!mode11) begin
                txBit_r <= shTx_r[WIDTH-1];
                shTx_r <= {shTx_r[WIDTH-2:0], 1'b0};
              end else begin
                shRx_r <= {shRx_r[WIDTH-2:0], rxDataPinIn};
              end
            end
          end
          ST_HOLD: begin
            txDrv_r <= 1'b0;
            if (phaseEnd) begin
              state_r <= ST_IDLE;
              frame_r <= 1'b0;
            end else begin
              divCnt_r <= divCnt_r - 1'b1;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Slave edge detection
  // ------------------------------------------------------------
  assign slvSel = (rxFramePolarity ? !rxFramePinIn : rxFramePinIn) &&
    (txFramePolarity ? !txFramePinIn : txFramePinIn);
  assign slvClk = txClockPolarity ? !txBitClockPinIn : txBitClockPinIn;
  assign slvRise = slvClk && !slvClkD_r;
  assign slvFall = !slvClk && slvClkD_r;
  assign slvLaunch = slvSel && (mode11 ? slvFall : slvRise);
  assign slvSample = slvSel && (mode11 ? slvRise : slvFall);

  always @(posedge sys_clk) begin
    if (srst) begin
      slvClkD_r <= 1'b0;
      slvSelD_r <= 1'b0;
      slvActive_r <= 1'b0;
    end else begin
      slvClkD_r <= slvClk;
      slvSelD_r <= slvSel;
      slvActive_r <= isSlave && slvSel;
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  assign busy = (state_r != ST_IDLE) || slvActive_r;
  assign txBitClockPinOut = isMaster ? (sclk_r ^ txClockPolarity) :
    gpioOut_r[`SSPG_PIN_TXCLK];
  assign txBitClockPinOe = isMaster || outOk[`SSPG_PIN_TXCLK];
  assign txFramePinOut = isMaster ?
    (txFramePolarity ? !frame_r : frame_r) :
    gpioOut_r[`SSPG_PIN_TXFRM];
  assign txFramePinOe = isMaster || outOk[`SSPG_PIN_TXFRM];
  assign txDataPinOut = spiEnable ? txBit_r : gpioOut_r[`SSPG_PIN_TXDAT];
  assign txDataPinOe = spiEnable ? txDrv_r : outOk[`SSPG_PIN_TXDAT];
  assign rxBitClockPinOut = gpioOut_r[`SSPG_PIN_RXCLK];
  assign rxBitClockPinOe = !spiEnable && outOk[`SSPG_PIN_RXCLK];
  assign rxFramePinOut = gpioOut_r[`SSPG_PIN_RXFRM];
  assign rxFramePinOe = !spiEnable && outOk[`SSPG_PIN_RXFRM];
endmodule
`default_nettype wire

/* test/sspg_port_assertions.sv */
// Clock-stop pin timing checker for the serial port
`include "sspg_defines.vh"
`default_nettype none
module sspg_port_chk #(
  parameter DIVW = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spiEnable,
  input wire logic spiMaster,
  input wire logic [1:0] clockStopMode,
  input wire logic txClockPolarity,
  input wire logic txFramePolarity,
  input wire logic [DIVW-1:0] clockDivideValue,
  input wire logic txBitClockPinIn,
  input wire logic txBitClockPinOut,
  input wire logic txFramePinIn,
  input wire logic txFramePinOut,
  input wire logic txDataPinOut,
  input wire logic txDataPinOe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [DIVW:0] ONE = 1;
  logic [DIVW:0] perLen, lowLen, runCnt_r, leadCnt_r, sinceFall_r;
  logic sclkQ_r, frameQ_r, seenRise_r, mActQ_r;
  wire sclk = txBitClockPinOut ^ txClockPolarity;
  wire frameAct = txFramePinOut ^ txFramePolarity;
  wire mAct = spiEnable && spiMaster && mActQ_r;
  wire sAct = spiEnable && !spiMaster && txFramePolarity;
  wire riseNow = sclk && !sclkQ_r;
  wire relNow = mAct && frameQ_r && !frameAct;
  wire pinClk = (spiMaster ? txBitClockPinOut : txBitClockPinIn)
    ^ txClockPolarity;
  wire is10 = clockStopMode == `SSPG_MODE_10;
  assign perLen = {1'b0, clockDivideValue} + ONE;
  assign lowLen = (clockDivideValue[0] || clockDivideValue == 0) ?
    perLen >> 1 : {1'b0, clockDivideValue} >> 1;
  // --------------------------------
  // Run and lead counters
  // --------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      sclkQ_r <= 1'b0;
      frameQ_r <= 1'b0;
      mActQ_r <= 1'b0;
      seenRise_r <= 1'b0;
      runCnt_r <= '0;
      sinceFall_r <= '0;
      leadCnt_r <= '0;
    end else begin
      sclkQ_r <= sclk;
      frameQ_r <= frameAct;
      mActQ_r <= spiEnable && spiMaster;
      runCnt_r <= (sclk != sclkQ_r) ? ONE : runCnt_r + ONE;
      sinceFall_r <= (!sclk && sclkQ_r) ? ONE : sinceFall_r + ONE;
      seenRise_r <= frameAct && (seenRise_r || riseNow);
      leadCnt_r <= !frameAct ? '0 : seenRise_r ? leadCnt_r : leadCnt_r + ONE;
    end
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_sel_fall;
    sAct && $fell(txFramePinIn);
  endsequence
  sequence s_sel_rise;
    sAct && $rose(txFramePinIn);
  endsequence
  property p_idle;
    mAct && !frameAct |-> !sclk;
  endproperty
  property p_frame_low;
    mAct && txFramePolarity && sclk |-> !txFramePinOut;
  endproperty
  property p_lead;
    mAct && riseNow && !seenRise_r |-> leadCnt_r == (is10 ? lowLen : perLen);
  endproperty
  property p_low;
    mAct && riseNow && seenRise_r |-> runCnt_r == lowLen;
  endproperty
  property p_high;
    mAct && !sclk && sclkQ_r |-> runCnt_r == perLen - lowLen;
  endproperty
  property p_hold;
    relNow |-> sinceFall_r == (is10 ? perLen : lowLen);
  endproperty
  property p_mfloat;
    relNow |-> !txDataPinOe;
  endproperty
  property p_launch;
    spiEnable && txDataPinOe && $past(txDataPinOe) && $changed(txDataPinOut)
      |-> pinClk == is10;
  endproperty
  property p_sdrive;
    s_sel_fall |-> ##[1:9] txDataPinOe;
  endproperty
  property p_sfloat;
    s_sel_rise |-> ##[1:9] !txDataPinOe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("bit clock moved outside a word");
  a_frame_low: assert property (p_frame_low)
    else $error("slave enable not low while clock high");
  a_lead: assert property (p_lead)
    else $error("wrong enable lead before first rise");
  a_low: assert property (p_low)
    else $error("wrong bit clock low time");
  a_high: assert property (p_high)
    else $error("wrong bit clock high time");
  a_hold: assert property (p_hold)
    else $error("wrong enable hold after last fall");
  a_mfloat: assert property (p_mfloat)
    else $error("data still driven at enable release");
  a_launch: assert property (p_launch)
    else $error("data changed in wrong clock phase");
  a_sdrive: assert property (p_sdrive)
    else $error("slave did not drive data after select");
  a_sfloat: assert property (p_sfloat)
    else $error("slave did not release data after deselect");
endmodule
bind sspg_port sspg_port_chk #(.DIVW(DIVW)) sspg_port_chk_i (
  .sys_clk(sys_clk), .srst(srst), .spiEnable(spiEnable),
  .spiMaster(spiMaster), .clockStopMode(clockStopMode),
  .txClockPolarity(txClockPolarity), .txFramePolarity(txFramePolarity),
  .clockDivideValue(clockDivideValue), .txBitClockPinIn(txBitClockPinIn),
  .txBitClockPinOut(txBitClockPinOut), .txFramePinIn(txFramePinIn),
  .txFramePinOut(txFramePinOut), .txDataPinOut(txDataPinOut),
  .txDataPinOe(txDataPinOe));
`default_nettype wire

/* test/sspg_port_tb.sv */
// Self-checking bench of the serial port GPIO and clock-stop block
`include "sspg_defines.vh"
`default_nettype none
module sspg_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, srst = 1, spiEnable = 0, spiMaster = 0, peerMaster = 0;
  logic txValid = 0, txClockPolarity = 0;
  logic txFramePolarity = 1, rxFramePolarity = 1;
  logic [5:0] gpioEnable = 0, gpioOutSel = 0, gpioOutLevel = 0, pinDrv = 0;
  logic [5:0] gpioInLevel, inM, outM;
  logic [1:0] clockStopMode = `SSPG_MODE_10;
  logic [7:0] clockDivideValue = 8'h01;
  logic [15:0] txWord = 0, rxWord;
  logic [15:0] txQ[$], rxQ[$];
  logic [9:0] cfg[4] = '{10'h201, 10'h301, 10'h204, 10'h303};
  logic txReady, rxValid, busy;
  wire [5:0] oeV, outV, lvl, drv;
  wire pClk, pSelN, pData;
  int failures = 0, compares = 0, i;
  assign oeV[2] = 1'b0;
  assign outV[2] = 1'b0;
  assign drv = spiEnable ? {pinDrv[5], pSelN, pClk, pData, pSelN, pinDrv[0]}
    : pinDrv;
  assign lvl = (oeV & outV) | (~oeV & drv);
  always #2 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (rxValid === 1'b1) rxQ.push_back(rxWord);
  sspg_port sspg_port_i (.sys_clk(sys_clk), .srst(srst),
    .gpioEnable(gpioEnable), .gpioOutSel(gpioOutSel),
    .gpioOutLevel(gpioOutLevel), .gpioInLevel(gpioInLevel),
    .spiEnable(spiEnable), .spiMaster(spiMaster),
    .clockStopMode(clockStopMode), .txClockPolarity(txClockPolarity),
    .txFramePolarity(txFramePolarity), .rxFramePolarity(rxFramePolarity),
    .clockDivideValue(clockDivideValue), .txValid(txValid),
    .txReady(txReady), .txWord(txWord), .rxValid(rxValid),
    .rxWord(rxWord), .busy(busy), .rxBitClockPinIn(lvl[0]),
    .rxBitClockPinOut(outV[0]), .rxBitClockPinOe(oeV[0]),
    .rxFramePinIn(lvl[1]), .rxFramePinOut(outV[1]),
    .rxFramePinOe(oeV[1]), .rxDataPinIn(lvl[2]),
    .txBitClockPinIn(lvl[3]), .txBitClockPinOut(outV[3]),
    .txBitClockPinOe(oeV[3]), .txFramePinIn(lvl[4]),
    .txFramePinOut(outV[4]), .txFramePinOe(oeV[4]),
    .txDataPinIn(lvl[5]), .txDataPinOut(outV[5]), .txDataPinOe(oeV[5]));
  sspg_spi_peer sspg_spi_peer_i (.sys_clk(sys_clk), .act(spiEnable),
    .peerMaster(peerMaster), .mode11(clockStopMode == `SSPG_MODE_11),
    .devClk(lvl[3] ^ txClockPolarity), .devSelN(lvl[4]), .devData(lvl[5]),
    .ownClk(pClk), .ownSelN(pSelN), .peerData(pData));
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic compare_words();
    logic [15:0] a, b;
    check("tx_count", 16'(sspg_spi_peer_i.gotQ.size()), 16'(txQ.size()));
    while (txQ.size() > 0 && sspg_spi_peer_i.gotQ.size() > 0) begin
      a = sspg_spi_peer_i.gotQ.pop_front();
      b = txQ.pop_front();
      check("tx_word", a, b);
    end
    check("rx_count", 16'(rxQ.size()), 16'(sspg_spi_peer_i.sentQ.size()));
    while (rxQ.size() > 0 && sspg_spi_peer_i.sentQ.size() > 0) begin
      a = rxQ.pop_front();
      b = sspg_spi_peer_i.sentQ.pop_front();
      check("rx_word", a, b);
    end
    sspg_spi_peer_i.gotQ.delete();
    sspg_spi_peer_i.sentQ.delete();
  endtask
  task automatic stop_test();
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    srst = 0;
    void'($urandom(32'h5761));
    // --------------------------------
    // GPIO directions and levels
    // --------------------------------
    repeat (24) begin
      {gpioEnable, gpioOutSel} = 12'($urandom);
      gpioOutLevel = 6'($urandom);
      pinDrv = 6'($urandom);
      repeat (2) @(negedge sys_clk);
      inM = gpioEnable & ~gpioOutSel & `SSPG_GPIO_IN_OK;
      outM = gpioEnable & gpioOutSel & `SSPG_GPIO_OUT_OK;
      check("gpio_in", 16'(gpioInLevel), 16'(pinDrv & inM));
      check("gpio_oe", 16'(oeV), 16'(outM));
      check("gpio_out", 16'(outV & outM), 16'(gpioOutLevel & outM));
    end
    gpioEnable = 0;
    // --------------------------------
    // Master words in both modes
    // --------------------------------
    foreach (cfg[k]) begin
      spiEnable = 0;
      spiMaster = 1;
      {clockStopMode, clockDivideValue} = cfg[k];
      txClockPolarity = k[1];
      txValid = 1;
      repeat (4) begin
        txWord = 16'($urandom);
        txQ.push_back(txWord);
        check("fifo_ready", 16'(txReady), 16'h1);
        @(negedge sys_clk);
      end
      check("fifo_full", 16'(txReady), 16'h0);
      txValid = 0;
      spiEnable = 1;
      @(negedge sys_clk);
      check("busy_on", 16'(busy), 16'h1);
      for (i = 0; i < 4000 && (busy !== 0 || txReady !== 1 ||
          sspg_spi_peer_i.gotQ.size() < 4); i++) @(negedge sys_clk);
      check("busy_off", 16'(busy), 16'h0);
      repeat (4) @(negedge sys_clk);
      compare_words();
    end
    // --------------------------------
    // Slave words from the far master
    // --------------------------------
    spiEnable = 0;
    spiMaster = 0;
    clockStopMode = `SSPG_MODE_10;
    txClockPolarity = 0;
    clockDivideValue = 8'h01;
    txValid = 1;
    txWord = 16'($urandom);
    @(negedge sys_clk);
    txValid = 0;
    txQ.push_back(txWord);
    txQ.push_back(txWord);
    spiEnable = 1;
    peerMaster = 1;
    repeat (2) sspg_spi_peer_i.master_word();
    repeat (20) @(negedge sys_clk);
    compare_words();
    stop_test();
  end
endmodule
`default_nettype wire

/* test/sspg_spi_peer.sv */
// Far-side SPI peer: slave to a master port, master to a slave port
`default_nettype none
module sspg_spi_peer (
  input wire logic sys_clk,
  input wire logic act,
  input wire logic peerMaster,
  input wire logic mode11,
  input wire logic devClk,
  input wire logic devSelN,
  input wire logic devData,
  output var logic ownClk,
  output var logic ownSelN,
  output var logic peerData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sendW, gotW;
  logic [15:0] sentQ[$], gotQ[$];
  int cnt;
  wire clk = peerMaster ? ownClk : devClk;
  wire selN = !act || (peerMaster ? ownSelN : devSelN);
  initial begin
    ownClk = 1'b0;
    ownSelN = 1'b1;
    peerData = 1'b0;
    cnt = 16;
  end
  always @(negedge selN) begin
    sendW = 16'($urandom);
    cnt = 0;
    peerData = sendW[15];
  end
  // Released line shows no stale level
  always @(posedge selN) peerData = ~peerData;
  always @(clk) begin
    if (!selN && clk == mode11) begin
      gotW = {gotW[14:0], devData};
      cnt++;
      if (cnt == 16) begin
        gotQ.push_back(gotW);
        sentQ.push_back(sendW);
      end
    end else if (!selN && cnt > 0 && cnt < 16) begin
      peerData = sendW[15 - cnt];
    end
  end
  task automatic master_word();
    repeat (10) @(negedge sys_clk);
    ownSelN = 1'b0;
    repeat (10) @(negedge sys_clk);
    repeat (32) begin
      ownClk = ~ownClk;
      repeat (10) @(negedge sys_clk);
    end
    ownSelN = 1'b1;
  endtask
endmodule
`default_nettype wire
